/* File: verilog/ecsw_defs.vh */
// constants for the eight-channel i2c switch control block
// assumes inclusion by ecsw_top.v only
`ifndef ECSW_DEFS_VH
`define ECSW_DEFS_VH
`define ECSW_ADDR_UPPER 4'hE
`define ECSW_CHAN_RESET 8'h00
`define ECSW_BIT_MSB 3'h7
`define ECSW_BIT_ZERO 3'h0
`define ECSW_POR_CYCLES 4'hF
`endif

/* File: verilog/ecsw_top.v */
// i2c slave holding the channel select register of an eight-channel switch
// assumes scl and sda arrive asynchronously and are sampled by sys_clk
//
// Contract
// - matching read address is acked, then register shifted out msb first
// - master nacks last byte then stops; device releases data on nack
// - byte after acked write address is stored; register is readable
// - bit n of active register enables downstream channel n
// - any combination of the eight channels may be enabled
// - new selection connects channels only after a STOP
// - every write data byte is acked; last one is kept
// - register clears to zero at power-up and every reset
// - active-low reset pin clears register, state machine, channels
// - internal power-on reset holds everything until released
// - address is upper pattern 1110 plus three select pins
`timescale 1ns/1ns
`include "ecsw_defs.vh"
module ecsw_top (
   input wire SYS_CLK,
   input wire RESET,
   input wire RESET_N,
   input wire SCL,
   input wire SDA_IN,
   output wire SDA_OUT,
   output wire SDA_OE,
   input wire ADDR_SELECT_PIN_LOW,
   input wire ADDR_SELECT_PIN_MID,
   input wire ADDR_SELECT_PIN_HIGH,
   output wire [7:0] CHANNEL_ENABLE
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RDATA = 3'h5;
   localparam ST_RACK = 3'h6;

   reg [1:0] scl_sync_reg;
   reg [1:0] sda_sync_reg;
   reg [1:0] rst_sync_reg;
   reg [2:0] pin_sync1_reg;
   reg [2:0] pin_sync2_reg;
   reg scl_d_reg;
   reg sda_d_reg;
   reg [3:0] por_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [2:0] bit_reg;
   reg [2:0] bit_next;
   reg [7:0] shift_reg;
   reg [7:0] shift_next;
   reg [7:0] select_reg;
   reg [7:0] select_next;
   reg [7:0] active_reg;
   reg [7:0] active_next;
   reg rw_reg;
   reg rw_next;
   reg drive_reg;
   reg drive_next;
   reg out_reg;
   reg out_next;
   reg byte_reg;
   reg byte_next;

   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   // local reset: pin low or power-on counter not yet expired
   wire soft_rst = ~rst_sync_reg[1] | (por_reg != `ECSW_POR_CYCLES);
   wire [6:0] my_addr = {`ECSW_ADDR_UPPER, pin_sync2_reg};

   assign SDA_OUT = out_reg;
   assign SDA_OE = drive_reg;
   assign CHANNEL_ENABLE = active_reg;

   always @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         rst_sync_reg <= 2'h0;
         pin_sync1_reg <= 3'h0;
         pin_sync2_reg <= 3'h0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         por_reg <= 4'h0;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], SCL};
         sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
         rst_sync_reg <= {rst_sync_reg[0], RESET_N};
         pin_sync1_reg <= {ADDR_SELECT_PIN_HIGH, ADDR_SELECT_PIN_MID,
            ADDR_SELECT_PIN_LOW};
         pin_sync2_reg <= pin_sync1_reg;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         if (por_reg != `ECSW_POR_CYCLES)
            por_reg <= por_reg + 4'h1;
      end
   end

   always @*
   begin
      state_next = state_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      select_next = select_reg;
      active_next = active_reg;
      rw_next = rw_reg;
      drive_next = drive_reg;
      out_next = out_reg;
      byte_next = byte_reg;
      if (stop_cond)
      begin
         state_next = ST_IDLE;
         drive_next = 1'b0;
         active_next = select_reg;
      end
      else if (start_cond)
      begin
         state_next = ST_ADDR;
         bit_next = `ECSW_BIT_MSB;
         byte_next = 1'b0;
         drive_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
               state_next = ST_IDLE;
            ST_ADDR, ST_WDATA:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next = bit_reg - 3'h1;
                  // eighth rising edge completes the byte
                  if (bit_reg == `ECSW_BIT_ZERO)
                     byte_next = 1'b1;
               end
               else if (scl_fall && byte_reg)
               begin
                  // eight bits taken: decide on acknowledge
                  // the first fall after start carries no data
                  byte_next = 1'b0;
                  if (state_reg == ST_WDATA)
                  begin
                     select_next = shift_reg;
                     state_next = ST_WACK;
                     drive_next = 1'b1;
                     out_next = 1'b0;
                  end
                  else if (shift_reg[7:1] == my_addr)
                  begin
                     rw_next = shift_reg[0];
                     state_next = ST_AACK;
                     drive_next = 1'b1;
                     out_next = 1'b0;
                  end
                  else
                     state_next = ST_IDLE;
               end
            end
            ST_AACK, ST_WACK:
               if (scl_fall)
               begin
                  bit_next = `ECSW_BIT_MSB;
                  if (rw_reg)
                  begin
                     state_next = ST_RDATA;
                     shift_next = select_reg;
                     out_next = select_reg[7];
                     drive_next = ~select_reg[7];
                  end
                  else
                  begin
                     state_next = ST_WDATA;
                     drive_next = 1'b0;
                  end
               end
            ST_RDATA:
               if (scl_fall)
               begin
                  if (bit_reg == `ECSW_BIT_ZERO)
                  begin
                     state_next = ST_RACK;
                     drive_next = 1'b0;
                  end
                  else
                  begin
                     bit_next = bit_reg - 3'h1;
                     shift_next = {shift_reg[6:0], 1'b0};
                     // open drain: only a zero is driven
                     out_next = shift_reg[6];
                     drive_next = ~shift_reg[6];
                  end
               end
            ST_RACK:
               if (scl_rise)
               begin
                  if (sda_s)
                     state_next = ST_IDLE;
                  else
                     bit_next = `ECSW_BIT_MSB;
               end
               else if (scl_fall && bit_reg == `ECSW_BIT_MSB)
               begin
                  state_next = ST_RDATA;
                  bit_next = `ECSW_BIT_MSB;
                  shift_next = select_reg;
                  out_next = select_reg[7];
                  drive_next = ~select_reg[7];
               end
            default:
               state_next = ST_IDLE;
         endcase
      end
   end

   always @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state_reg <= ST_IDLE;
         bit_reg <= `ECSW_BIT_ZERO;
         shift_reg <= `ECSW_CHAN_RESET;
         select_reg <= `ECSW_CHAN_RESET;
         active_reg <= `ECSW_CHAN_RESET;
         rw_reg <= 1'b0;
         byte_reg <= 1'b0;
         drive_reg <= 1'b0;
         out_reg <= 1'b0;
      end
      else if (soft_rst)
      begin
         state_reg <= ST_IDLE;
         bit_reg <= `ECSW_BIT_ZERO;
         shift_reg <= `ECSW_CHAN_RESET;
         select_reg <= `ECSW_CHAN_RESET;
         active_reg <= `ECSW_CHAN_RESET;
         rw_reg <= 1'b0;
         byte_reg <= 1'b0;
         drive_reg <= 1'b0;
         out_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         select_reg <= select_next;
         active_reg <= active_next;
         rw_reg <= rw_next;
         byte_reg <= byte_next;
         drive_reg <= drive_next;
         out_reg <= out_next;
      end
   end
endmodule // ecsw_top

/* File: testbench/ecsw_top_asserts.sv */
// timing checks on the switch control top ports
// assumes it is bound onto ecsw_top
`timescale 1ns/1ns
module ecsw_top_asserts (
   input wire SYS_CLK,
   input wire RESET,
   input wire RESET_N,
   input wire SCL,
   input wire SDA_IN,
   input wire SDA_OUT,
   input wire SDA_OE,
   input wire [7:0] CHANNEL_ENABLE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   drain_only_a: assert property (SDA_OE |-> !SDA_OUT)
      else $error("sda driven high");
   chan_on_stop_a: assert property ($changed(CHANNEL_ENABLE) |->
      (SCL && SDA_IN) || CHANNEL_ENABLE == 8'h00)
      else $error("channels moved early");
   pin_reset_a: assert property (!RESET_N [*6] |->
      CHANNEL_ENABLE == 8'h00 && !SDA_OE) else $error("reset pin ignored");
   drive_start_a: assert property ($rose(SDA_OE) |-> !SCL)
      else $error("drive began with scl high");
   drive_end_a: assert property ($fell(SDA_OE) |-> !SCL)
      else $error("release with scl high");
   por_quiet_a: assert property ($fell(RESET) |-> !SDA_OE [*8])
      else $error("sda driven after power reset");
   por_clear_a: assert property ($fell(RESET) |->
      CHANNEL_ENABLE == 8'h00) else $error("channels set after reset");
   sda_steady_a: assert property (SCL && $past(SCL) |->
      $stable(SDA_OE)) else $error("sda moved while scl high");
endmodule // ecsw_top_asserts

/* File: testbench/ecsw_master.sv */
// upstream bus master model with open-drain data pull
// assumes a pull-up resolves the wire outside
`timescale 1ns/1ns
module ecsw_master (
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   initial
   begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   task automatic start;
      pull_low = 1'b1;
      #80 scl = 1'b0;
      #40;
   endtask
   task automatic stop;
      pull_low = 1'b1;
      #40 scl = 1'b1;
      #80 pull_low = 1'b0;
      #80;
   endtask
   // data released when sending ones, so reads and acks share this
   task automatic xfer(input logic [7:0] d, input logic ak,
      output logic [7:0] q, output logic a);
      for (int i = 8; i >= 0; i--)
      begin
         pull_low = (i > 0) ? !d[i-1] : !ak;
         #40 scl = 1'b1;
         #40 if (i > 0) q[i-1] = sda; else a = sda;
         #40 scl = 1'b0;
         #40;
      end
   endtask
endmodule // ecsw_master

/* File: testbench/i2c_eight_channel_switch_control_bench.sv */
// bench for the switch control block with a bus master model
// assumes ecsw_top and ecsw_master are compiled first
`timescale 1ns/1ns
module i2c_eight_channel_switch_control_bench;
   typedef struct {logic [2:0] p; logic [6:0] a; logic [7:0] d; logic n;}
      ecsw_row_t;
   ecsw_row_t rows[5] = '{'{3'h0, 7'h70, 8'hA5, 1'b0},
      '{3'h7, 7'h77, 8'hFF, 1'b0}, '{3'h5, 7'h75, 8'h00, 1'b0},
      '{3'h2, 7'h72, 8'h5A, 1'b0}, '{3'h3, 7'h71, 8'h3C, 1'b1}};
   logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, scl, m_low, oe, so, ack;
   logic [2:0] pins = 3'h0;
   logic [7:0] chan, q, ce = 8'h00;
   wire sda = !(m_low | (oe & !so));
   int bad_count = 0, comparisons = 0;
   ecsw_top dut_u (.SYS_CLK(clk), .RESET(rst), .RESET_N(rst_n), .SCL(scl),
      .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe),
      .ADDR_SELECT_PIN_LOW(pins[0]), .ADDR_SELECT_PIN_MID(pins[1]),
      .ADDR_SELECT_PIN_HIGH(pins[2]), .CHANNEL_ENABLE(chan));
   ecsw_master m_u (.scl(scl), .pull_low(m_low), .sda(sda));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] exp);
      m_u.start;
      m_u.xfer({a, 1'b1}, 1'b1, q, ack);
      m_u.xfer(8'hFF, 1'b1, q, ack);
      m_u.stop;
      chk(q, exp);
   endtask
   initial
   begin
      forever #4 clk = !clk;
   end
   initial
   begin
      #500000 bad_count++;
      test_done;
   end
   initial
   begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (30) @(negedge clk);
      foreach (rows[i])
      begin
         pins = rows[i].p;
         repeat (4) @(negedge clk);
         m_u.start;
         m_u.xfer({rows[i].a, 1'b0}, 1'b1, q, ack);
         chk({7'h00, ack}, {7'h00, rows[i].n});
         m_u.xfer(rows[i].d, 1'b1, q, ack);
         chk(chan, ce);
         m_u.stop;
         repeat (8) @(negedge clk);
         if (!rows[i].n) ce = rows[i].d;
         chk(chan, ce);
         rd(rows[i].a, rows[i].n ? 8'hFF : ce);
      end
      m_u.start;
      m_u.xfer(8'hE6, 1'b1, q, ack);
      m_u.xfer(8'h11, 1'b1, q, ack);
      m_u.xfer(8'h81, 1'b1, q, ack);
      chk({7'h00, ack}, 8'h00);
      m_u.stop;
      repeat (8) @(negedge clk);
      chk(chan, 8'h81);
      m_u.start;
      m_u.xfer(8'hE7, 1'b1, q, ack);
      m_u.xfer(8'hFF, 1'b0, q, ack);
      chk(q, 8'h81);
      m_u.xfer(8'hFF, 1'b1, q, ack);
      m_u.stop;
      chk(q, 8'h81);
      chk({7'h00, oe}, 8'h00);
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk(chan, 8'h00);
      repeat (10) @(negedge clk);
      rd(7'h73, 8'h00);
      m_u.start;
      m_u.xfer(8'hE6, 1'b1, q, ack);
      m_u.xfer(8'h3C, 1'b1, q, ack);
      m_u.stop;
      repeat (8) @(negedge clk);
      chk(chan, 8'h3C);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      chk(chan, 8'h00);
      rst = 1'b0;
      repeat (30) @(negedge clk);
      rd(7'h73, 8'h00);
      test_done;
   end
endmodule // i2c_eight_channel_switch_control_bench
bind ecsw_top ecsw_top_asserts chk_u (.SYS_CLK(SYS_CLK), .RESET(RESET),
   .RESET_N(RESET_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .CHANNEL_ENABLE(CHANNEL_ENABLE));
